//--- fsp_flash_ctrl.sv
// Program flash access, sector protection and in-circuit link
//
// Notes on behaviour
// - Whole or per-sector erase, byte programming
// - Sector erase touches only its sector
// - Tool modes may alter every sector, options
// - Application mode never alters sector 0
// - Up to three sectors, two of 4K
// - Sector 0 spans F000h to FFFFh
// - Present sectors follow the array size
// - Lock blocks read-out and all writes
// - Removing the lock erases everything first
// - One lock bit in the option byte
// - Key guard before application program, erase
// - Link timed by its own serial clock
// - One shared data line, driven in turn
// - Tool present takes the link pins
`timescale 1ns/1ps
`default_nettype none
`include "fsp_params.svh"

module fsp_flash_ctrl #(
    parameter logic [16:0] FLASH_BYTES = `FSP_FLASH_BYTES
) (
    // System clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    // In-circuit link
    input  wire logic               i_prog_serial_clock,
    input  wire logic               i_prog_serial_data,
    output logic                    o_prog_serial_data,
    output logic                    o_prog_serial_data_oe_n,
    input  wire logic               i_session,
    input  wire logic               i_tool_present,
    output logic                    o_pins_owned,
    // Option byte as stored
    input  wire logic               i_opt_lock,
    output logic                    o_readout_lock,
    // Application requests
    input  wire logic               i_cpu_key_valid,
    input  wire logic [7:0]         i_cpu_key,
    input  wire logic               i_cpu_req,
    input  wire fsp_pkg::fsp_frame_t i_cpu_frame,
    output logic                    o_cpu_done,
    output logic                    o_cpu_ok,
    output logic                    o_cpu_busy,
    // Flash array
    output var fsp_pkg::fsp_flash_t o_flash,
    input  wire logic               i_flash_done,
    input  wire logic [7:0]         i_flash_rdata
);

    fsp_pkg::fsp_sys_t   s_q;
    fsp_pkg::fsp_sys_t   s_d;
    fsp_pkg::fsp_link_t  l_q;
    fsp_pkg::fsp_link_t  l_d;
    fsp_pkg::fsp_frame_t cand;
    logic                take_tool;
    logic                take_cpu;
    logic                sect_valid;
    logic [1:0]          sect;
    logic                writable;
    logic                go;
    logic                hard_rst;
    logic                frame_rst;

    // ------------------------------------------------------------
    // Candidate request and its sector
    // ------------------------------------------------------------
    // Tool frame beats an application request in the same cycle
    assign take_tool = (s_q.fs2 ^ s_q.fs3) && s_q.sess2 && s_q.loaded;
    assign take_cpu  = i_cpu_req && !take_tool && s_q.loaded &&
                       (s_q.guard == `FSP_GUARD_ARMED);
    assign cand      = take_tool ? l_q.word : i_cpu_frame;

    fsp_sector_map #(
        .FLASH_BYTES (FLASH_BYTES)
    ) u_map (
        .i_addr   (cand.addr),
        .o_valid  (sect_valid),
        .o_sector (sect)
    );

    // Tool may alter all sectors, application all but sector 0
    assign writable = sect_valid && !s_q.lock &&
                      (take_tool || sect != `FSP_SECT0);

    always_comb begin
        go = 1'b0;
        case (cand.cmd)
            `FSP_CMD_READ:  go = take_tool && !s_q.lock;
            `FSP_CMD_PROG:  go = writable;
            `FSP_CMD_ESECT: go = writable;
            `FSP_CMD_EALL:  go = take_tool && !s_q.lock;
            `FSP_CMD_OPT:   go = take_tool;
            default:        go = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // System domain
    // ------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.fs1      = l_q.frame_tgl;
        s_d.fs2      = s_q.fs1;
        s_d.fs3      = s_q.fs2;
        s_d.sess1    = i_session;
        s_d.sess2    = s_q.sess1;
        s_d.pres1    = i_tool_present;
        s_d.pres2    = s_q.pres1;
        s_d.cpu_done = 1'b0;

        // Stored option byte is caught once after reset release
        if (!s_q.loaded) begin
            s_d.lock   = i_opt_lock;
            s_d.loaded = 1'b1;
        end

        // Any stray key, or any application request while in ST_IDLE, drops the guard
        if (i_cpu_key_valid) begin
            if (i_cpu_key == `FSP_KEY1) begin
                s_d.guard = `FSP_GUARD_HALF;
            end else if (s_q.guard == `FSP_GUARD_HALF &&
                         i_cpu_key == `FSP_KEY2) begin
                s_d.guard = `FSP_GUARD_ARMED;
            end else begin
                s_d.guard = `FSP_GUARD_IDLE;
            end
        end

        case (s_q.st)
            fsp_pkg::ST_IDLE: begin
                if (i_cpu_req) begin
                    s_d.guard = `FSP_GUARD_IDLE;
                end
                if (take_tool || take_cpu) begin
                    s_d.req          = cand;
                    s_d.from_tool    = take_tool;
                    s_d.flash.addr   = cand.addr;
                    s_d.flash.wdata  = cand.data;
                    s_d.flash.sector = sect;
                    if (!go) begin
                        // Refused: flash untouched
                        if (take_tool && cand.cmd == `FSP_CMD_READ) begin
                            s_d.resp_byte = `FSP_BLOCKED_BYTE;
                            s_d.resp_tgl  = !s_q.resp_tgl;
                        end
                        if (take_cpu) begin
                            s_d.cpu_done = 1'b1;
                            s_d.cpu_ok   = 1'b0;
                        end
                    end else if (cand.cmd == `FSP_CMD_OPT) begin
                        if (s_q.lock && !cand.data[`FSP_OPT_LOCK_BIT]) begin
                            // Unlock only after a full erase
                            s_d.opt_clear = 1'b1;
                            s_d.flash.op  = `FSP_OP_EALL;
                            s_d.st        = fsp_pkg::ST_ISSUE;
                        end else begin
                            s_d.lock = cand.data[`FSP_OPT_LOCK_BIT];
                        end
                    end else begin
                        case (cand.cmd)
                            `FSP_CMD_READ:  s_d.flash.op = `FSP_OP_READ;
                            `FSP_CMD_PROG:  s_d.flash.op = `FSP_OP_PROG;
                            `FSP_CMD_ESECT: s_d.flash.op = `FSP_OP_ESECT;
                            default:        s_d.flash.op = `FSP_OP_EALL;
                        endcase
                        s_d.st = fsp_pkg::ST_ISSUE;
                    end
                end
            end
            fsp_pkg::ST_ISSUE: begin
                s_d.flash.req = 1'b1;
                s_d.st        = fsp_pkg::ST_WAIT;
            end
            fsp_pkg::ST_WAIT: begin
                if (i_flash_done) begin
                    s_d.flash.req = 1'b0;
                    s_d.st        = fsp_pkg::ST_IDLE;
                    if (s_q.flash.op == `FSP_OP_READ) begin
                        s_d.resp_byte = i_flash_rdata;
                        s_d.resp_tgl  = !s_q.resp_tgl;
                    end
                    if (s_q.opt_clear) begin
                        s_d.opt_clear = 1'b0;
                        s_d.lock      = 1'b0;
                    end
                    if (!s_q.from_tool) begin
                        s_d.cpu_done = 1'b1;
                        s_d.cpu_ok   = 1'b1;
                    end
                end
            end
            default: begin
                s_d.st = fsp_pkg::ST_IDLE;
            end
        endcase

        s_d.busy       = (s_d.st != fsp_pkg::ST_IDLE);
        s_d.pins_owned = s_q.pres2;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s_q      <= '0;
            s_q.st   <= fsp_pkg::ST_IDLE;
            s_q.lock <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    // Session drop only restarts framing, toggles stay intact
    assign hard_rst  = !l_q.rst2;
    assign frame_rst = hard_rst || !l_q.sess2;

    always_comb begin
        l_d       = l_q;
        l_d.rst1  = i_rstn;
        l_d.rst2  = l_q.rst1;
        l_d.sess1 = i_session;
        l_d.sess2 = l_q.sess1;
        l_d.resp1 = s_q.resp_tgl;
        l_d.resp2 = l_q.resp1;
        if (frame_rst) begin
            l_d.cnt  = '0;
            l_d.oe_n = 1'b1;
            l_d.dout = 1'b0;
            if (hard_rst) begin
                l_d.frame_tgl = 1'b0;
                l_d.resp_ack  = 1'b0;
                l_d.word      = '0;
            end
        end else begin
            // Answer bits lead the frame, then the line is handed over
            if (l_q.cnt == '0 && l_q.resp2 != l_q.resp_ack) begin
                l_d.dout      = s_q.resp_byte[7];
                l_d.shift_out = {s_q.resp_byte[6:0], 1'b0};
                l_d.oe_n      = 1'b0;
                l_d.resp_ack  = l_q.resp2;
            end else if (l_q.cnt == `FSP_RESP_RELEASE) begin
                l_d.oe_n = 1'b1;
            end else if (!l_q.oe_n) begin
                l_d.dout      = l_q.shift_out[7];
                l_d.shift_out = {l_q.shift_out[6:0], 1'b0};
            end
            if (l_q.cnt > `FSP_RESP_RELEASE) begin
                l_d.shift_in = {l_q.shift_in[26:0], i_prog_serial_data};
            end
            if (l_q.cnt == `FSP_FRAME_LAST) begin
                l_d.word      = {l_q.shift_in[26:0], i_prog_serial_data};
                l_d.frame_tgl = !l_q.frame_tgl;
                l_d.cnt       = '0;
            end else begin
                l_d.cnt = 6'(l_q.cnt + `FSP_CNT_STEP);
            end
        end
    end

    always_ff @(posedge i_prog_serial_clock) begin
        l_q <= l_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_prog_serial_data      = l_q.dout;
    assign o_prog_serial_data_oe_n = l_q.oe_n;
    assign o_pins_owned            = s_q.pins_owned;
    assign o_readout_lock          = s_q.lock;
    assign o_cpu_done              = s_q.cpu_done;
    assign o_cpu_ok                = s_q.cpu_ok;
    assign o_cpu_busy              = s_q.busy;
    assign o_flash                 = s_q.flash;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_iap_sector0: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_flash.req && !s_q.from_tool && o_flash.op != `FSP_OP_READ
        |-> o_flash.sector != `FSP_SECT0)
        else $error("application altered sector 0");

    chk_lock_blocks: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_flash.req && s_q.lock |-> s_q.opt_clear &&
        o_flash.op == `FSP_OP_EALL)
        else $error("flash access while locked");

    chk_unlock_erase: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $fell(o_readout_lock) && $past(s_q.loaded)
        |-> $past(s_q.opt_clear && i_flash_done && o_flash.req))
        else $error("lock removed without full erase");

    chk_guard_arm: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(o_flash.req) && !s_q.from_tool
        |-> $past(s_q.guard, 2) == `FSP_GUARD_ARMED)
        else $error("application operation without guard");

    chk_req_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_flash.req && !i_flash_done |=> o_flash.req)
        else $error("flash request dropped early");

    chk_sect_avail: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_flash.req && (o_flash.op == `FSP_OP_PROG ||
        o_flash.op == `FSP_OP_ESECT)
        |-> (FLASH_BYTES > `FSP_SECT_BYTES || o_flash.sector == `FSP_SECT0) &&
            (FLASH_BYTES > 17'(2 * `FSP_SECT_BYTES) ||
             o_flash.sector != `FSP_SECT2))
        else $error("absent sector addressed");

    chk_refuse_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
        s_q.st == fsp_pkg::ST_IDLE && (take_tool || take_cpu) && !go
        |=> !o_flash.req [*2])
        else $error("forbidden request reached flash");

    chk_pins_taken: assert property (@(posedge i_clk) disable iff (!i_rstn)
        s_q.pres2 ##1 s_q.pres2 |-> o_pins_owned)
        else $error("link pins left to application");

    chk_line_release: assert property (@(posedge i_prog_serial_clock)
        disable iff (frame_rst)
        l_q.cnt > `FSP_RESP_RELEASE |-> l_q.oe_n)
        else $error("device drives line in tool slot");

    chk_frame_len: assert property (@(posedge i_prog_serial_clock)
        disable iff (hard_rst)
        $changed(l_q.frame_tgl) |-> $past(l_q.cnt) == `FSP_FRAME_LAST)
        else $error("frame closed at wrong bit");

    cov_tool_prog: cover property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(o_flash.req) && s_q.from_tool && o_flash.op == `FSP_OP_PROG);

    cov_cpu_prog: cover property (@(posedge i_clk) disable iff (!i_rstn)
        o_cpu_done && o_cpu_ok);

    cov_unlock: cover property (@(posedge i_clk) disable iff (!i_rstn)
        $fell(o_readout_lock) && $past(s_q.opt_clear));

    cov_answer: cover property (@(posedge i_prog_serial_clock)
        disable iff (frame_rst)
        !l_q.oe_n ##8 l_q.oe_n);

endmodule // fsp_flash_ctrl
`default_nettype wire

//--- fsp_flash_ctrl_tb_top.sv
// Self-checking bench for the flash sector program and protect block
`timescale 1ns/1ps
`default_nettype none
`include "fsp_params.svh"

module fsp_flash_ctrl_tb_top;
    localparam logic [16:0] SZ [3] = '{17'h01000, 17'h02000, 17'h08000};
    localparam logic [27:0] M_OP  = 28'hC000000;
    localparam logic [27:0] M_SEC = 28'hF000000;
    localparam logic [27:0] M_RD  = 28'hCFFFF00;
    localparam logic [27:0] M_ALL = 28'hFFFFFFF;

    logic                clk   = 1'b0;
    logic                rstn  = 1'b0;
    logic                kv    = 1'b0;
    logic                req   = 1'b0;
    logic                fdone = 1'b0;
    logic                req_q = 1'b0;
    logic [7:0]          key   = 8'h00;
    logic                optl  = 1'b0;
    logic [1:0]          wcnt  = 2'h0;
    fsp_pkg::fsp_frame_t frm   = '0;
    fsp_pkg::fsp_flash_t fl, lst;
    logic                sclk, line, sess, tp, dd, doe_n, own, lock;
    logic                done, ok, busy;
    logic [7:0]          ans;
    int                  n_iss = 0;
    int                  n_base = 0;
    int                  error_cnt = 0;
    int                  num_checks = 0;

    always #12.5 clk = ~clk;

    fsp_tool_model tool (.i_dev_data(dd), .i_dev_oe_n(doe_n),
        .o_clk(sclk), .o_line(line), .o_session(sess), .o_present(tp));

    fsp_flash_ctrl #(.FLASH_BYTES(SZ[2])) dut (.i_clk(clk),
        .i_rstn(rstn), .i_prog_serial_clock(sclk),
        .i_prog_serial_data(line), .o_prog_serial_data(dd),
        .o_prog_serial_data_oe_n(doe_n), .i_session(sess),
        .i_tool_present(tp), .o_pins_owned(own), .i_opt_lock(optl),
        .o_readout_lock(lock), .i_cpu_key_valid(kv), .i_cpu_key(key),
        .i_cpu_req(req), .i_cpu_frame(frm), .o_cpu_done(done),
        .o_cpu_ok(ok), .o_cpu_busy(busy), .o_flash(fl),
        .i_flash_done(fdone), .i_flash_rdata(fl.addr[7:0] ^ 8'h5A));

    // ------------------------------------------------------------
    // Array model: logs each request, answers after three cycles
    // ------------------------------------------------------------
    always @(posedge clk) begin
        fdone <= 1'b0;
        req_q <= fl.req;
        if (fl.req && !fdone) begin
            if (!req_q) begin
                n_iss <= n_iss + 1;
                lst   <= fl;
                chk1("busy", 1'b1, busy);
            end
            wcnt <= wcnt + 2'h1;
            if (wcnt == 2'h2) begin
                fdone <= 1'b1;
                wcnt  <= 2'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Compare, request and closing tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic issued(input logic [27:0] e, input logic [27:0] m);
        for (int k = 0; k < 80 && n_iss == n_base; k++) @(posedge clk);
        chk("issue count", 32'h1, n_iss - n_base);
        chk("issue fields", {4'h0, e & m},
            {4'h0, m & {lst.op, lst.sector, lst.addr, lst.wdata}});
        for (int k = 0; k < 80 && (busy || fl.req); k++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask

    task automatic none_issued();
        repeat (40) @(posedge clk);
        chk("no issue", 32'h0, n_iss - n_base);
    endtask

    task automatic cpu_op(input logic arm, input logic [3:0] cmd,
                          input logic [15:0] addr, input logic e_ok);
        n_base = n_iss;
        if (arm) begin
            @(posedge clk);
            kv  <= 1'b1;
            key <= `FSP_KEY1;
            @(posedge clk);
            key <= `FSP_KEY2;
        end
        @(posedge clk);
        kv  <= 1'b0;
        req <= 1'b1;
        frm <= {cmd, addr, 8'h3C};
        @(posedge clk);
        req <= 1'b0;
        for (int k = 0; k < 40 && done !== 1'b1; k++) @(posedge clk);
        chk1("cpu done", arm, done);
        if (arm) chk1("cpu ok", e_ok, ok);
    endtask

    task automatic tool_op(input logic [3:0] cmd, input logic [15:0] a,
                           input logic [7:0] d);
        n_base = n_iss;
        tool.frame(cmd, a, d, ans);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        tool.tick(4);
        repeat (2) @(posedge clk);
        chk1("lock in reset", 1'b1, lock);
        chk("flash idle", 32'h0, {3'h0, fl});
        chk1("pins free", 1'b0, own);
        rstn <= 1'b1;
        tool.tick(4);
        repeat (3) @(posedge clk);
        chk1("lock loaded", 1'b0, lock);
    endtask

    task automatic t_map();
        logic [15:0] at [5];
        logic [1:0]  s;
        at = '{16'hFFFF, 16'hE000, 16'hDFFF, 16'h8000, 16'h7FFF};
        for (int i = 0; i < 5; i++) begin
            s = at[i] >= 16'hF000 ? 2'h0 : at[i] >= 16'hE000 ? 2'h1 :
                at[i] >= 16'h8000 ? 2'h2 : 2'h3;
            tool_op(`FSP_CMD_PROG, at[i], 8'h00);
            if (s == 2'h3) none_issued();
            else issued({`FSP_OP_PROG, s, at[i], 8'h00}, M_ALL);
        end
    endtask

    task automatic t_app();
        cpu_op(1'b1, `FSP_CMD_PROG, 16'hE010, 1'b1);
        issued({`FSP_OP_PROG, `FSP_SECT1, 16'hE010, 8'h3C}, M_ALL);
        cpu_op(1'b1, `FSP_CMD_PROG, 16'h8000, 1'b1);
        issued({`FSP_OP_PROG, `FSP_SECT2, 16'h8000, 8'h3C}, M_ALL);
        cpu_op(1'b1, `FSP_CMD_ESECT, 16'hE800, 1'b1);
        issued({`FSP_OP_ESECT, `FSP_SECT1, 24'h0}, M_SEC);
        cpu_op(1'b1, `FSP_CMD_PROG, 16'hF000, 1'b0);
        none_issued();
        cpu_op(1'b1, `FSP_CMD_ESECT, 16'hF800, 1'b0);
        none_issued();
        cpu_op(1'b1, `FSP_CMD_PROG, 16'h7FFF, 1'b0);
        none_issued();
        cpu_op(1'b0, `FSP_CMD_PROG, 16'hE020, 1'b0);
        none_issued();
    endtask

    task automatic t_tool();
        tool.plug();
        repeat (6) @(posedge clk);
        chk1("pins owned", 1'b1, own);
        tool.open_session();
        tool_op(`FSP_CMD_PROG, 16'hF001, 8'hA5);
        issued({`FSP_OP_PROG, `FSP_SECT0, 16'hF001, 8'hA5}, M_ALL);
        tool_op(`FSP_CMD_ESECT, 16'hF000, 8'h00);
        issued({`FSP_OP_ESECT, `FSP_SECT0, 24'h0}, M_SEC);
        tool_op(`FSP_CMD_EALL, 16'h0000, 8'h00);
        issued({`FSP_OP_EALL, 26'h0}, M_OP);
        tool_op(`FSP_CMD_READ, 16'hE123, 8'h00);
        issued({`FSP_OP_READ, 2'h0, 16'hE123, 8'h00}, M_RD);
        // Link clock stops between frames: one frame to sync the answer
        tool_op(4'h0, 16'h0000, 8'h00);
        tool_op(4'h0, 16'h0000, 8'h00);
        chk("tool read", 32'h23 ^ 32'h5A, {24'h0, ans});
    endtask

    task automatic t_lock();
        tool_op(`FSP_CMD_OPT, 16'h0000, 8'h01);
        repeat (10) @(posedge clk);
        chk1("lock set", 1'b1, lock);
        tool_op(`FSP_CMD_READ, 16'hE123, 8'h00);
        repeat (20) @(posedge clk);
        tool_op(4'h0, 16'h0000, 8'h00);
        tool_op(4'h0, 16'h0000, 8'h00);
        chk("locked read", 32'h0, {24'h0, ans});
        tool_op(`FSP_CMD_PROG, 16'hE000, 8'h11);
        none_issued();
        cpu_op(1'b1, `FSP_CMD_PROG, 16'hE010, 1'b0);
        none_issued();
        tool_op(`FSP_CMD_OPT, 16'h0000, 8'h00);
        for (int k = 0; k < 80 && fl.req !== 1'b1; k++) @(posedge clk);
        chk1("lock held", 1'b1, lock);
        issued({`FSP_OP_EALL, 26'h0}, M_OP);
        chk1("lock cleared", 1'b0, lock);
    endtask

    // Mid-run reset with the stored lock bit set
    task automatic t_reload();
        optl <= 1'b1;
        rstn <= 1'b0;
        tool.tick(4);
        @(posedge clk) rstn <= 1'b1;
        tool.tick(4);
        repeat (3) @(posedge clk);
        chk1("lock reloaded", 1'b1, lock);
    endtask

    initial begin
        t_reset();
        t_app();
        t_tool();
        t_map();
        t_lock();
        t_reload();
        end_sim();
    end

    // Whole run needs about 40 us
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
endmodule // fsp_flash_ctrl_tb_top

`default_nettype wire

//--- fsp_params.svh
// Constants for the flash sector program and protect block
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// Link frame commands
`define FSP_CMD_READ        4'h1
`define FSP_CMD_PROG        4'h2
`define FSP_CMD_ESECT       4'h3
`define FSP_CMD_EALL        4'h4
`define FSP_CMD_OPT         4'h5

// Operations toward the flash array
`define FSP_OP_READ         2'h0
`define FSP_OP_PROG         2'h1
`define FSP_OP_ESECT        2'h2
`define FSP_OP_EALL         2'h3

// Sector map
`define FSP_SECT0           2'h0
`define FSP_SECT1           2'h1
`define FSP_SECT2           2'h2
`define FSP_SECT0_BASE      17'h0F000
`define FSP_SECT1_BASE      17'h0E000
`define FSP_SECT_BYTES      17'h01000
`define FSP_ADDR_TOP        17'h10000
`define FSP_FLASH_BYTES     17'h08000

// Access guard keys and states
`define FSP_KEY1            8'h56
`define FSP_KEY2            8'hAE
`define FSP_GUARD_IDLE      2'h0
`define FSP_GUARD_HALF      2'h1
`define FSP_GUARD_ARMED     2'h2

// Option byte and link framing
`define FSP_OPT_LOCK_BIT    0
`define FSP_BLOCKED_BYTE    8'h00
`define FSP_RESP_RELEASE    6'h08
`define FSP_FRAME_LAST      6'h24
`define FSP_CNT_STEP        6'h01

`endif

//--- fsp_pkg.sv
// Types shared by the flash sector program and protect block
package fsp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_ISSUE = 3'h2,
        ST_WAIT  = 3'h4
    } fsp_state_t;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [15:0] addr;
        logic [7:0]  data;
    } fsp_frame_t;

    typedef struct packed {
        logic        req;
        logic [1:0]  op;
        logic [1:0]  sector;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fsp_flash_t;

    typedef struct packed {
        logic        fs1;
        logic        fs2;
        logic        fs3;
        logic        sess1;
        logic        sess2;
        logic        pres1;
        logic        pres2;
        fsp_state_t  st;
        fsp_frame_t  req;
        logic        from_tool;
        logic        opt_clear;
        logic        lock;
        logic        loaded;
        logic [1:0]  guard;
        logic [7:0]  resp_byte;
        logic        resp_tgl;
        fsp_flash_t  flash;
        logic        cpu_done;
        logic        cpu_ok;
        logic        busy;
        logic        pins_owned;
    } fsp_sys_t;

    typedef struct packed {
        logic        rst1;
        logic        rst2;
        logic        sess1;
        logic        sess2;
        logic        resp1;
        logic        resp2;
        logic        resp_ack;
        logic [5:0]  cnt;
        logic [27:0] shift_in;
        logic [7:0]  shift_out;
        logic        dout;
        logic        oe_n;
        fsp_frame_t  word;
        logic        frame_tgl;
    } fsp_link_t;

endpackage

//--- fsp_sector_map.sv
// Address to sector decoder for the program flash
`timescale 1ns/1ps
`default_nettype none
`include "fsp_params.svh"

module fsp_sector_map #(
    parameter logic [16:0] FLASH_BYTES = `FSP_FLASH_BYTES
) (
    // Address in
    input  wire logic [15:0] i_addr,
    // Decode out
    output logic             o_valid,
    output logic [1:0]       o_sector
);

    logic [16:0] addr_w;
    logic [16:0] base_w;

    assign addr_w = {1'b0, i_addr};
    assign base_w = 17'(`FSP_ADDR_TOP - FLASH_BYTES);

    // Sector 0 on top holds the vectors, sector 2 takes the rest
    always_comb begin
        o_valid  = 1'b0;
        o_sector = `FSP_SECT0;
        if (addr_w >= `FSP_SECT0_BASE) begin
            o_valid = 1'b1;
        end else if (FLASH_BYTES > `FSP_SECT_BYTES &&
                     addr_w >= `FSP_SECT1_BASE) begin
            o_valid  = 1'b1;
            o_sector = `FSP_SECT1;
        end else if (FLASH_BYTES > 17'(2 * `FSP_SECT_BYTES) &&
                     addr_w >= base_w) begin
            o_valid  = 1'b1;
            o_sector = `FSP_SECT2;
        end
    end

endmodule // fsp_sector_map
`default_nettype wire

//--- fsp_tool_model.sv
// Programming tool model for the in-circuit link
`timescale 1ns/1ps
`default_nettype none

module fsp_tool_model (
    // Device side of the data line
    input  wire logic i_dev_data,
    input  wire logic i_dev_oe_n,
    // Link pins and session
    output logic      o_clk,
    output logic      o_line,
    output logic      o_session,
    output logic      o_present
);
    logic drv  = 1'b0;
    logic tval = 1'b0;
    logic junk = 1'b0;

    // Released line toggles so a stale bit never passes for an answer
    assign o_line = !i_dev_oe_n ? i_dev_data : (drv ? tval : junk);

    initial begin
        o_clk     = 1'b0;
        o_session = 1'b0;
        o_present = 1'b0;
    end

    task automatic plug();
        o_present = 1'b1;
    endtask

    // Tool raises the session and runs two link clocks before any frame
    task automatic open_session();
        o_session = 1'b1;
        tick(2);
    endtask

    // Link clock runs only inside tick and frame calls
    task automatic tick(input int n);
        repeat (n) begin
            #15 o_clk = 1'b1;
            #1 junk = ~junk;
            #14 o_clk = 1'b0;
        end
    endtask

    task automatic frame(input logic [3:0] c, input logic [15:0] a,
                         input logic [7:0] d, output logic [7:0] ans);
        logic [27:0] w;
        w   = {c, a, d};
        ans = 8'h00;
        for (int i = 0; i <= 36; i++) begin
            #15;
            // Device bit taken as it stands before the edge
            if (i >= 1 && i <= 8) ans = {ans[6:0], o_line};
            o_clk = 1'b1;
            #1 junk = ~junk;
            drv = (i >= 8 && i < 36);
            if (drv) tval = w[35-i];
            #14 o_clk = 1'b0;
        end
    endtask
endmodule // fsp_tool_model

`default_nettype wire
